// [inc/idcr_consts.svh]
// Register offsets, field positions and reset values of the converter control bank
// Overview of operation
// - Soft-reset bit restores all registers but common_control
// - Mode bit picks separate or interleaved I/Q ports
// - Chip power-down stops all but the serial port
// - Bandgap power-down bit switches references off
// - Oscillator disabled holds phase accumulator at zero
// - Low-power mode uses five upper frequency/phase bits
// - Modulation field decodes five sideband modes
// - Divider field is divide or clock delay
// - Frequency word built from four byte registers
// - Phase word built from two byte registers
// - Coarse gain split over two registers
// - Channel A offset split over two registers
// - Channel B offset split likewise
// - Auxiliary value from high/low registers, power bit
// - Coding bit picks offset binary or two's complement
// - Count bits give one to four data bytes
// - Multi-byte transfer steps to lower addresses
`ifndef IDCR_CONSTS_SVH
`define IDCR_CONSTS_SVH
`define IDCR_A_COMMON 5'h00
`define IDCR_A_TRANSMIT_CONFIG 5'h01
`define IDCR_A_CLKCFG 5'h02
`define IDCR_A_FREQ0 5'h03
`define IDCR_A_FREQ1 5'h04
`define IDCR_A_FREQ2 5'h05
`define IDCR_A_FREQ3 5'h06
`define IDCR_A_PHLO 5'h07
`define IDCR_A_PHHI 5'h08
`define IDCR_A_CHA1 5'h09
`define IDCR_A_CHA2 5'h0A
`define IDCR_A_CHA3 5'h0B
`define IDCR_A_CHB1 5'h0C
`define IDCR_A_CHB2 5'h0D
`define IDCR_A_CHB3 5'h0E
`define IDCR_A_CONV 5'h0F
`define IDCR_A_SYNC 5'h10
`define IDCR_A_TUNE17 5'h11
`define IDCR_A_GAP 5'h12
`define IDCR_A_TUNE19 5'h13
`define IDCR_A_TUNE20 5'h14
`define IDCR_A_AUXAH 5'h1A
`define IDCR_A_AUXAL 5'h1B
`define IDCR_A_AUXBH 5'h1C
`define IDCR_A_AUXBL 5'h1D
`define IDCR_NREG 32
`define IDCR_B_SOFTRST 6
`define IDCR_B_LATCH_FALL 5
`define IDCR_B_MODE 3
`define IDCR_B_CODING 2
`define IDCR_B_CHIPPD 1
`define IDCR_B_GAPPD 0
`define IDCR_B_OSCEN 7
`define IDCR_B_OSCLP 6
`define IDCR_B_ROLLOFF 5
`define IDCR_B_MULTPD 7
`define IDCR_B_DIVPD 5
`define IDCR_B_PWROFF 7
`define IDCR_B_SLEEP 6
`define IDCR_M_COMMON 8'hEF
`define IDCR_M_CLKCFG 8'hBF
`define IDCR_M_CONV 8'h03
`define IDCR_M_SYNC 8'hC0
`define IDCR_M_AUXL 8'h83
`define IDCR_RST_COMMON 8'h80
`define IDCR_RST_TRANSMIT_CONFIG 8'h87
`define IDCR_RST_CLKCFG 8'h10
`define IDCR_RST_FREQ 8'h66
`define IDCR_RST_FREQ3 8'h26
`define IDCR_RST_GAIN2 8'h40
`define IDCR_RST_GAIN3 8'hC0
`define IDCR_RST_AUXH 8'h80
`define IDCR_PS_PER_DELAY_STEP 150
`define IDCR_PS_DELAY_BASE 130
`endif

// [inc/idcr_pkg.sv]
// Types shared by the converter control bank
package idcr_pkg;
	typedef enum logic [4:0]
	{
		IDCR_MOD_DUAL = 5'b00001,
		IDCR_MOD_POS_UPPER = 5'b00010,
		IDCR_MOD_POS_LOWER = 5'b00100,
		IDCR_MOD_NEG_UPPER = 5'b01000,
		IDCR_MOD_NEG_LOWER = 5'b10000
	} idcr_mod_t;
	typedef enum logic [2:0]
	{
		IDCR_ST_INSTR = 3'b001,
		IDCR_ST_DATA = 3'b010,
		IDCR_ST_DONE = 3'b100
	} idcr_state_t;
	typedef struct packed
	{
		logic [3:0] coarseGain;
		logic [5:0] fineGain;
		logic [11:0] offset;
		logic powerOff;
		logic sleep;
		logic [9:0] auxValue;
		logic auxPowerOff;
	} idcr_chan_t;
	typedef struct packed
	{
		logic interleaved;
		logic latchFalling;
		logic twosComplement;
		logic chipPowerDown;
		logic bandgapPowerDown;
		logic oscillatorEnable;
		logic oscillatorLowPower;
		logic rolloffCompensationEnable;
		idcr_mod_t modulation;
		logic [1:0] interpolation;
		logic multiplierPowerDown;
		logic dividerPowerDown;
		logic [1:0] divSelect;
		logic [3:0] divideRatio;
		logic [9:0] clockDelayPs;
		logic [1:0] sampleClockPhase;
		logic sampleClockInvert;
		logic [31:0] oscillatorFreqWord;
		logic [15:0] oscillatorPhaseWord;
		logic modulatorGainCut;
		logic noiseShapingEnable;
		logic syncDivideBy8;
		logic syncEnable;
	} idcr_cfg_t;
endpackage

// [rtl/idcr_ctrl_regs.sv]
// Serial register port and configuration bank of the dual interpolating converter
`timescale 1ns/1ps
`include "idcr_consts.svh"
module idcr_ctrl_regs
	import idcr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic serClk,
	input wire logic serSel_n,
	input wire logic serDataIn,
	output logic serDataOut,
	output logic serDataOe,
	output idcr_cfg_t cfg,
	output idcr_chan_t chanA,
	output idcr_chan_t chanB,
	output logic coreEnable,
	output logic [31:0] oscPhaseAcc
);
	logic [1:0] sclkSync_ff;
	logic [1:0] selSync_ff;
	logic [1:0] sdiSync_ff;
	logic sclkRise;
	logic sclkFall;
	logic selActive;
	logic selEnd;
	logic sclkPrev_ff;
	logic selPrev_ff;
	idcr_state_t state_ff;
	idcr_state_t nxt_state;
	logic [7:0] shift_ff;
	logic [2:0] bitCnt_ff;
	logic [2:0] byteLeft_ff;
	logic [4:0] addr_ff;
	logic isRead_ff;
	logic byteDone;
	logic [7:0] shiftNext;
	logic [7:0] regs_ff [`IDCR_NREG];
	logic [7:0] outByte_ff;
	logic softRst_ff;
	logic writeByte;
	logic [31:0] phaseAcc_ff;

	function automatic logic [7:0] idcr_mask(input logic [4:0] a);
		unique case (a)
			`IDCR_A_COMMON: idcr_mask = `IDCR_M_COMMON;
			`IDCR_A_CLKCFG: idcr_mask = `IDCR_M_CLKCFG;
			`IDCR_A_CONV: idcr_mask = `IDCR_M_CONV;
			`IDCR_A_SYNC: idcr_mask = `IDCR_M_SYNC;
			`IDCR_A_AUXAL, `IDCR_A_AUXBL: idcr_mask = `IDCR_M_AUXL;
			`IDCR_A_TRANSMIT_CONFIG, `IDCR_A_FREQ0, `IDCR_A_FREQ1, `IDCR_A_FREQ2, `IDCR_A_FREQ3,
			`IDCR_A_PHLO, `IDCR_A_PHHI, `IDCR_A_CHA1, `IDCR_A_CHA2, `IDCR_A_CHA3,
			`IDCR_A_CHB1, `IDCR_A_CHB2, `IDCR_A_CHB3, `IDCR_A_TUNE17, `IDCR_A_TUNE19,
			`IDCR_A_TUNE20, `IDCR_A_AUXAH, `IDCR_A_AUXBH: idcr_mask = 8'hFF;
			default: idcr_mask = 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] idcr_reset_val(input logic [4:0] a);
		unique case (a)
			`IDCR_A_COMMON: idcr_reset_val = `IDCR_RST_COMMON;
			`IDCR_A_TRANSMIT_CONFIG: idcr_reset_val = `IDCR_RST_TRANSMIT_CONFIG;
			`IDCR_A_CLKCFG: idcr_reset_val = `IDCR_RST_CLKCFG;
			`IDCR_A_FREQ0, `IDCR_A_FREQ1, `IDCR_A_FREQ2: idcr_reset_val = `IDCR_RST_FREQ;
			`IDCR_A_FREQ3: idcr_reset_val = `IDCR_RST_FREQ3;
			`IDCR_A_CHA2, `IDCR_A_CHB2: idcr_reset_val = `IDCR_RST_GAIN2;
			`IDCR_A_CHA3, `IDCR_A_CHB3: idcr_reset_val = `IDCR_RST_GAIN3;
			`IDCR_A_AUXAH, `IDCR_A_AUXBH: idcr_reset_val = `IDCR_RST_AUXH;
			default: idcr_reset_val = 8'h00;
		endcase
	endfunction

	// Serial pins come from another clock; two flops before any use
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclkSync_ff <= 2'h0;
			selSync_ff <= 2'h3;
			sdiSync_ff <= 2'h0;
			sclkPrev_ff <= 1'b0;
			selPrev_ff <= 1'b1;
		end
		else
		begin
			sclkSync_ff <= {sclkSync_ff[0], serClk};
			selSync_ff <= {selSync_ff[0], serSel_n};
			sdiSync_ff <= {sdiSync_ff[0], serDataIn};
			sclkPrev_ff <= sclkSync_ff[1];
			selPrev_ff <= selSync_ff[1];
		end
	end

	assign selActive = !selSync_ff[1];
	assign sclkRise = selActive && sclkSync_ff[1] && !sclkPrev_ff;
	assign sclkFall = selActive && !sclkSync_ff[1] && sclkPrev_ff;
	assign selEnd = selSync_ff[1] && !selPrev_ff;
	assign shiftNext = {shift_ff[6:0], sdiSync_ff[1]};
	assign byteDone = sclkRise && (bitCnt_ff == 3'h7);
	// Writes land only on documented, writable bits; reserved bits stay zero
	assign writeByte = byteDone && (state_ff == IDCR_ST_DATA) && !isRead_ff;

	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			IDCR_ST_INSTR: if (byteDone) nxt_state = IDCR_ST_DATA;
			IDCR_ST_DATA: if (byteDone && byteLeft_ff == 3'h1) nxt_state = IDCR_ST_DONE;
			IDCR_ST_DONE: nxt_state = IDCR_ST_DONE;
		endcase
		if (!selActive)
			nxt_state = IDCR_ST_INSTR;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff <= IDCR_ST_INSTR;
			shift_ff <= 8'h00;
			bitCnt_ff <= 3'h0;
			byteLeft_ff <= 3'h0;
			addr_ff <= 5'h00;
			isRead_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			if (!selActive)
				bitCnt_ff <= 3'h0;
			else if (sclkRise)
			begin
				shift_ff <= shiftNext;
				bitCnt_ff <= bitCnt_ff + 3'h1;
			end
			if (byteDone && state_ff == IDCR_ST_INSTR)
			begin
				isRead_ff <= shift_ff[6];
				byteLeft_ff <= {1'b0, shift_ff[5:4]} + 3'h1;
				addr_ff <= shiftNext[4:0];
			end
			else if (byteDone && state_ff == IDCR_ST_DATA)
			begin
				byteLeft_ff <= byteLeft_ff - 3'h1;
				addr_ff <= addr_ff - 5'h01;
			end
		end
	end

	// Soft reset is held pending until the frame closes so the write completes
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			softRst_ff <= 1'b0;
		else if (writeByte && addr_ff == `IDCR_A_COMMON && shiftNext[`IDCR_B_SOFTRST])
			softRst_ff <= 1'b1;
		else if (selEnd)
			softRst_ff <= 1'b0;
	end

	genvar gi;
	generate
		for (gi = 0; gi < `IDCR_NREG; gi++)
		begin : g_reg
			localparam logic [4:0] ADDR = 5'(gi);
			always_ff @(posedge core_clk or negedge rst_n)
			begin
				if (!rst_n)
					regs_ff[gi] <= idcr_reset_val(ADDR);
				else if (softRst_ff && selEnd && ADDR != `IDCR_A_COMMON)
					regs_ff[gi] <= idcr_reset_val(ADDR);
				else if (writeByte && addr_ff == ADDR)
					regs_ff[gi] <= shiftNext & idcr_mask(ADDR);
			end
		end
	endgenerate

	// Read data shifts out MSB first; each byte loads on the rising serial edge ending the previous byte, later bits change on the falling edge
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			outByte_ff <= 8'h00;
		else if (byteDone && state_ff == IDCR_ST_INSTR)
			outByte_ff <= regs_ff[shiftNext[4:0]];
		else if (byteDone && state_ff == IDCR_ST_DATA)
			outByte_ff <= regs_ff[addr_ff - 5'h01];
		else if (sclkFall && bitCnt_ff != 3'h0)
			outByte_ff <= {outByte_ff[6:0], 1'b0};
	end

	assign serDataOut = outByte_ff[7];
	assign serDataOe = selActive && isRead_ff && (state_ff == IDCR_ST_DATA);

	// Field assembly for the datapath
	assign cfg.interleaved = regs_ff[`IDCR_A_COMMON][`IDCR_B_MODE];
	assign cfg.latchFalling = regs_ff[`IDCR_A_COMMON][`IDCR_B_LATCH_FALL];
	assign cfg.twosComplement = regs_ff[`IDCR_A_COMMON][`IDCR_B_CODING];
	assign cfg.chipPowerDown = regs_ff[`IDCR_A_COMMON][`IDCR_B_CHIPPD];
	assign cfg.bandgapPowerDown = regs_ff[`IDCR_A_COMMON][`IDCR_B_GAPPD];
	assign cfg.oscillatorEnable = regs_ff[`IDCR_A_TRANSMIT_CONFIG][`IDCR_B_OSCEN];
	assign cfg.oscillatorLowPower = regs_ff[`IDCR_A_TRANSMIT_CONFIG][`IDCR_B_OSCLP];
	assign cfg.rolloffCompensationEnable = regs_ff[`IDCR_A_TRANSMIT_CONFIG][`IDCR_B_ROLLOFF];
	assign cfg.interpolation = regs_ff[`IDCR_A_TRANSMIT_CONFIG][1:0];
	assign cfg.multiplierPowerDown = regs_ff[`IDCR_A_CLKCFG][`IDCR_B_MULTPD];
	assign cfg.dividerPowerDown = regs_ff[`IDCR_A_CLKCFG][`IDCR_B_DIVPD];
	assign cfg.divSelect = regs_ff[`IDCR_A_CLKCFG][4:3];
	// Divide ratio valid with multiplier on; delay valid with it off
	assign cfg.divideRatio = regs_ff[`IDCR_A_CLKCFG][`IDCR_B_MULTPD] ? 4'h0 :
		(regs_ff[`IDCR_A_CLKCFG][4:3] == 2'h3 ? 4'h0 :
		4'(4'h2 << regs_ff[`IDCR_A_CLKCFG][4:3]));
	assign cfg.clockDelayPs = !regs_ff[`IDCR_A_CLKCFG][`IDCR_B_MULTPD] ? 10'h000 :
		10'(`IDCR_PS_DELAY_BASE + `IDCR_PS_PER_DELAY_STEP * regs_ff[`IDCR_A_CLKCFG][4:3]);
	assign cfg.sampleClockPhase = regs_ff[`IDCR_A_CLKCFG][2:1];
	assign cfg.sampleClockInvert = regs_ff[`IDCR_A_CLKCFG][0];
	// Low-power oscillator keeps only the five top bits of each word
	assign cfg.oscillatorFreqWord = regs_ff[`IDCR_A_TRANSMIT_CONFIG][`IDCR_B_OSCLP] ?
		{regs_ff[`IDCR_A_FREQ3][7:3], 27'h0000000} :
		{regs_ff[`IDCR_A_FREQ3], regs_ff[`IDCR_A_FREQ2],
		regs_ff[`IDCR_A_FREQ1], regs_ff[`IDCR_A_FREQ0]};
	assign cfg.oscillatorPhaseWord = regs_ff[`IDCR_A_TRANSMIT_CONFIG][`IDCR_B_OSCLP] ?
		{regs_ff[`IDCR_A_PHHI][7:3], 11'h000} :
		{regs_ff[`IDCR_A_PHHI], regs_ff[`IDCR_A_PHLO]};
	assign cfg.modulatorGainCut = regs_ff[`IDCR_A_CONV][1];
	assign cfg.noiseShapingEnable = regs_ff[`IDCR_A_CONV][0];
	assign cfg.syncDivideBy8 = regs_ff[`IDCR_A_SYNC][7];
	assign cfg.syncEnable = regs_ff[`IDCR_A_SYNC][6];

	function automatic idcr_mod_t idcr_mod_decode(input logic [2:0] code);
		unique case (code)
			3'h1: idcr_mod_decode = IDCR_MOD_POS_UPPER;
			3'h2: idcr_mod_decode = IDCR_MOD_POS_LOWER;
			3'h3: idcr_mod_decode = IDCR_MOD_NEG_UPPER;
			3'h4: idcr_mod_decode = IDCR_MOD_NEG_LOWER;
			default: idcr_mod_decode = IDCR_MOD_DUAL;
		endcase
	endfunction

	assign cfg.modulation = idcr_mod_decode(regs_ff[`IDCR_A_TRANSMIT_CONFIG][4:2]);

	assign chanA.coarseGain = {regs_ff[`IDCR_A_CHA3][7:6], regs_ff[`IDCR_A_CHA2][7:6]};
	assign chanA.fineGain = regs_ff[`IDCR_A_CHA2][5:0];
	assign chanA.offset = {regs_ff[`IDCR_A_CHA3][5:0], regs_ff[`IDCR_A_CHA1][5:0]};
	assign chanA.powerOff = regs_ff[`IDCR_A_CHA1][`IDCR_B_PWROFF];
	assign chanA.sleep = regs_ff[`IDCR_A_CHA1][`IDCR_B_SLEEP];
	assign chanA.auxValue = {regs_ff[`IDCR_A_AUXAH], regs_ff[`IDCR_A_AUXAL][1:0]};
	assign chanA.auxPowerOff = regs_ff[`IDCR_A_AUXAL][`IDCR_B_PWROFF];
	assign chanB.coarseGain = {regs_ff[`IDCR_A_CHB3][7:6], regs_ff[`IDCR_A_CHB2][7:6]};
	assign chanB.fineGain = regs_ff[`IDCR_A_CHB2][5:0];
	assign chanB.offset = {regs_ff[`IDCR_A_CHB3][5:0], regs_ff[`IDCR_A_CHB1][5:0]};
	assign chanB.powerOff = regs_ff[`IDCR_A_CHB1][`IDCR_B_PWROFF];
	assign chanB.sleep = regs_ff[`IDCR_A_CHB1][`IDCR_B_SLEEP];
	assign chanB.auxValue = {regs_ff[`IDCR_A_AUXBH], regs_ff[`IDCR_A_AUXBL][1:0]};
	assign chanB.auxPowerOff = regs_ff[`IDCR_A_AUXBL][`IDCR_B_PWROFF];

	// Everything but the serial port is gated by chip power-down
	assign coreEnable = !regs_ff[`IDCR_A_COMMON][`IDCR_B_CHIPPD];

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			phaseAcc_ff <= 32'h00000000;
		else if (!regs_ff[`IDCR_A_TRANSMIT_CONFIG][`IDCR_B_OSCEN] || !coreEnable)
			phaseAcc_ff <= 32'h00000000;
		else
			phaseAcc_ff <= phaseAcc_ff + cfg.oscillatorFreqWord;
	end

	assign oscPhaseAcc = phaseAcc_ff;

	a_osc_held_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		!regs_ff[`IDCR_A_TRANSMIT_CONFIG][`IDCR_B_OSCEN]
		|=> oscPhaseAcc == 32'h0)
		else $error("phase accumulator not held while disabled");
	a_power_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
		cfg.chipPowerDown
		|-> !coreEnable)
		else $error("core enabled during chip power-down");
	a_soft_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
		softRst_ff && selEnd
		|=> regs_ff[`IDCR_A_TRANSMIT_CONFIG] == `IDCR_RST_TRANSMIT_CONFIG && $stable(regs_ff[`IDCR_A_COMMON]))
		else $error("soft reset did not restore defaults");
	a_addr_down: assert property (@(posedge core_clk) disable iff (!rst_n)
		byteDone && state_ff == IDCR_ST_DATA && selActive
		|=> addr_ff == $past(addr_ff) - 5'h01)
		else $error("address did not step down");
	a_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
		regs_ff[`IDCR_A_COMMON][4] == 1'b0 && regs_ff[`IDCR_A_CONV][7:2] == 6'h00
		&& regs_ff[`IDCR_A_GAP] == 8'h00)
		else $error("reserved bits not zero");
	a_byte_count: assert property (@(posedge core_clk) disable iff (!rst_n)
		byteDone && state_ff == IDCR_ST_INSTR && selActive
		|=> byteLeft_ff == {1'b0, $past(shift_ff[5:4])} + 3'h1)
		else $error("byte count decode wrong");
	a_lowpower_freq: assert property (@(posedge core_clk) disable iff (!rst_n)
		cfg.oscillatorLowPower
		|-> cfg.oscillatorFreqWord[26:0] == 27'h0 && cfg.oscillatorPhaseWord[10:0] == 11'h000)
		else $error("low-power words keep low bits");
	a_write_lands: assert property (@(posedge core_clk) disable iff (!rst_n)
		writeByte && addr_ff == `IDCR_A_PHLO
		|=> cfg.oscillatorPhaseWord[7:0] == $past(shiftNext) || cfg.oscillatorLowPower)
		else $error("phase byte not stored");
	a_mode_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		writeByte && addr_ff == `IDCR_A_COMMON
		|=> cfg.interleaved == $past(shiftNext[`IDCR_B_MODE]))
		else $error("data mode bit not applied");
	a_chip_down: assert property (@(posedge core_clk) disable iff (!rst_n)
		writeByte && addr_ff == `IDCR_A_COMMON && shiftNext[`IDCR_B_CHIPPD]
		|=> !coreEnable)
		else $error("chip power-down not applied");
	a_bandgap_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		writeByte && addr_ff == `IDCR_A_COMMON
		|=> cfg.bandgapPowerDown == $past(shiftNext[`IDCR_B_GAPPD]))
		else $error("bandgap power-down bit not applied");
	a_coding_write: assert property (@(posedge core_clk) disable iff (!rst_n)
		writeByte && addr_ff == `IDCR_A_COMMON
		|=> cfg.twosComplement == $past(shiftNext[`IDCR_B_CODING]))
		else $error("coding bit not applied");
	a_acc_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
		!coreEnable
		|=> oscPhaseAcc == 32'h0)
		else $error("accumulator runs during chip power-down");
	a_osc_runs: assert property (@(posedge core_clk) disable iff (!rst_n)
		cfg.oscillatorEnable && coreEnable
		|=> oscPhaseAcc == $past(oscPhaseAcc) + $past(cfg.oscillatorFreqWord))
		else $error("accumulator does not advance while enabled");
	a_mod_pos_lower: assert property (@(posedge core_clk) disable iff (!rst_n)
		writeByte && addr_ff == `IDCR_A_TRANSMIT_CONFIG && shiftNext[4:2] == 3'h2
		|=> cfg.modulation == IDCR_MOD_POS_LOWER)
		else $error("modulation code 2 decoded wrong");
	a_mod_neg_lower: assert property (@(posedge core_clk) disable iff (!rst_n)
		writeByte && addr_ff == `IDCR_A_TRANSMIT_CONFIG && shiftNext[4:2] == 3'h4
		|=> cfg.modulation == IDCR_MOD_NEG_LOWER)
		else $error("modulation code 4 decoded wrong");
	a_div_four: assert property (@(posedge core_clk) disable iff (!rst_n)
		!cfg.multiplierPowerDown && cfg.divSelect == 2'h1
		|-> cfg.divideRatio == 4'h4)
		else $error("divide ratio for code 1 wrong");
	a_delay_top: assert property (@(posedge core_clk) disable iff (!rst_n)
		cfg.multiplierPowerDown && cfg.divSelect == 2'h3
		|-> cfg.clockDelayPs == 10'(`IDCR_PS_DELAY_BASE + 3 * `IDCR_PS_PER_DELAY_STEP))
		else $error("clock delay for code 3 wrong");
	a_freq_low: assert property (@(posedge core_clk) disable iff (!rst_n)
		writeByte && addr_ff == `IDCR_A_FREQ0
		|=> cfg.oscillatorFreqWord[7:0] == $past(shiftNext) || cfg.oscillatorLowPower)
		else $error("frequency low byte not stored");
	a_freq_top: assert property (@(posedge core_clk) disable iff (!rst_n)
		writeByte && addr_ff == `IDCR_A_FREQ3
		|=> cfg.oscillatorFreqWord[31:27] == $past(shiftNext[7:3]))
		else $error("frequency top bits not stored");
	a_phase_top: assert property (@(posedge core_clk) disable iff (!rst_n)
		writeByte && addr_ff == `IDCR_A_PHHI
		|=> cfg.oscillatorPhaseWord[15:11] == $past(shiftNext[7:3]))
		else $error("phase top bits not stored");
	a_gain_split: assert property (@(posedge core_clk) disable iff (!rst_n)
		writeByte && addr_ff == `IDCR_A_CHA3
		|=> chanA.coarseGain[3:2] == $past(shiftNext[7:6]))
		else $error("coarse gain upper bits misplaced");
	a_fine_gain: assert property (@(posedge core_clk) disable iff (!rst_n)
		writeByte && addr_ff == `IDCR_A_CHB2
		|=> chanB.fineGain == $past(shiftNext[5:0]))
		else $error("fine gain not stored");
	a_offset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		writeByte && addr_ff == `IDCR_A_CHA1
		|=> chanA.offset[5:0] == $past(shiftNext[5:0]))
		else $error("channel A offset low bits misplaced");
	a_offset_b: assert property (@(posedge core_clk) disable iff (!rst_n)
		writeByte && addr_ff == `IDCR_A_CHB3
		|=> chanB.offset[11:6] == $past(shiftNext[5:0]))
		else $error("channel B offset high bits misplaced");
	a_aux_split: assert property (@(posedge core_clk) disable iff (!rst_n)
		writeByte && addr_ff == `IDCR_A_AUXAL
		|=> chanA.auxValue[1:0] == $past(shiftNext[1:0]) && chanA.auxPowerOff == $past(shiftNext[7]))
		else $error("auxiliary low register misplaced");
	a_read_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
		byteDone && state_ff == IDCR_ST_INSTR
		|=> isRead_ff == $past(shiftNext[7]))
		else $error("read flag not taken from instruction");
	a_count_done: assert property (@(posedge core_clk) disable iff (!rst_n)
		byteDone && state_ff == IDCR_ST_DATA && byteLeft_ff == 3'h1
		|=> state_ff == IDCR_ST_DONE)
		else $error("frame did not stop after last byte");
	a_soft_pending: assert property (@(posedge core_clk) disable iff (!rst_n)
		writeByte && addr_ff == `IDCR_A_COMMON && shiftNext[`IDCR_B_SOFTRST]
		|=> softRst_ff)
		else $error("soft reset not held pending");
endmodule // idcr_ctrl_regs

// [dv/idcr_host_model.sv]
// Host-side serial master model for the converter register port
`timescale 1ns/1ps
module idcr_host_model
(
	input wire logic core_clk,
	output logic serClk,
	output logic serSel_n,
	output logic hostData,
	input wire logic serDataOut,
	output logic [7:0] rdByte,
	output logic rdStrobe
);
	// Half period of 36 ns keeps the serial clock under 15 MHz
	localparam int HALF = 9;
	initial
	begin
		serClk = 1'b0;
		serSel_n = 1'b1;
		hostData = 1'b0;
		rdByte = 8'h00;
		rdStrobe = 1'b0;
	end
	task automatic half_wait();
		repeat (HALF) @(negedge core_clk);
	endtask
	task automatic xfer(input logic rw, input logic [1:0] cnt, input logic [4:0] addr,
		input logic [31:0] wd);
		logic [39:0] sh;
		logic [7:0] got;
		sh = {rw, cnt, addr, wd};
		got = 8'h00;
		@(negedge core_clk);
		serSel_n = 1'b0;
		half_wait();
		for (int i = 0; i < 8 * (cnt + 2); i++)
		begin
			// During reads the host line toggles so a stale level is never mistaken for data
			hostData = (rw && i >= 8) ? ~hostData : sh[39 - i];
			half_wait();
			got = {got[6:0], serDataOut};
			serClk = 1'b1;
			if (rw && i >= 8 && i % 8 == 7)
			begin
				rdByte = got;
				rdStrobe = 1'b1;
			end
			@(negedge core_clk);
			rdStrobe = 1'b0;
			repeat (HALF - 1) @(negedge core_clk);
			serClk = 1'b0;
		end
		half_wait();
		serSel_n = 1'b1;
		hostData = ~hostData;
		half_wait();
	endtask
endmodule // idcr_host_model

// [dv/interpolating_dac_control_regs_tb.sv]
// Self-checking bench for the converter control register bank
`timescale 1ns/1ps
module interpolating_dac_control_regs_tb
	import idcr_pkg::*;
;
	logic core_clk;
	logic rst_n;
	logic serClk;
	logic serSel_n;
	logic hostData;
	logic serDataOut;
	logic serDataOe;
	logic [7:0] rdByte;
	logic rdStrobe;
	idcr_cfg_t cfg;
	idcr_chan_t chanA;
	idcr_chan_t chanB;
	idcr_chan_t ch;
	logic coreEnable;
	logic [31:0] oscPhaseAcc;
	logic [7:0] expQ [$];
	logic [31:0] d;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	int seed = 40;
	localparam logic [4:0] ADR [24] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
		5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h13,
		5'h14, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
	localparam logic [7:0] DEF [24] = '{8'h80, 8'h87, 8'h10, 8'h66, 8'h66, 8'h66, 8'h26,
		8'h00, 8'h00, 8'h00, 8'h40, 8'hC0, 8'h00, 8'h40, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h80, 8'h00, 8'h80, 8'h00};
	// Shared data pin: the device wins while it drives read data
	wire logic serDataIn = serDataOe ? serDataOut : hostData;
	idcr_ctrl_regs i_dut (.core_clk(core_clk), .rst_n(rst_n), .serClk(serClk),
		.serSel_n(serSel_n), .serDataIn(serDataIn), .serDataOut(serDataOut),
		.serDataOe(serDataOe), .cfg(cfg), .chanA(chanA), .chanB(chanB),
		.coreEnable(coreEnable), .oscPhaseAcc(oscPhaseAcc));
	idcr_host_model host (.core_clk(core_clk), .serClk(serClk), .serSel_n(serSel_n),
		.hostData(hostData), .serDataOut(serDataOut), .rdByte(rdByte), .rdStrobe(rdStrobe));
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic end_of_test();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [1:0] c, input logic [31:0] v);
		host.xfer(1'b0, c, a, v);
		repeat (10) @(negedge core_clk);
	endtask
	task automatic rd(input logic [4:0] a, input logic [1:0] c, input logic [31:0] e);
		for (int k = 0; k <= c; k++)
			expQ.push_back(e[31 - 8 * k -: 8]);
		host.xfer(1'b1, c, a, 32'h0);
		repeat (10) @(negedge core_clk);
	endtask
	always @(posedge core_clk)
		if (rdStrobe === 1'b1)
		begin
			if (expQ.size() == 0)
				chk("unexpected read byte", 32'h0, 32'hFFFF_FFFF);
			else
				chk("read byte", expQ.pop_front(), rdByte);
		end
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			error_cnt++;
			end_of_test();
		end
	end
	initial
	begin
		rst_n = 1'b0;
		repeat (5) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge core_clk);
		for (int i = 0; i < 24; i++)
			rd(ADR[i], 2'd0, {DEF[i], 24'h0});
		rd(5'h12, 2'd1, 32'h0);
		$display("test defaults done");
		d = $random(seed);
		wr(5'h06, 2'd3, d);
		chk("freq word", d, cfg.oscillatorFreqWord);
		rd(5'h06, 2'd3, d);
		d = $random(seed);
		wr(5'h08, 2'd1, d);
		chk("phase word", d[31:16], cfg.oscillatorPhaseWord);
		$display("test oscillator words done");
		for (int k = 0; k < 2; k++)
		begin
			d = $random(seed);
			wr(k ? 5'h0E : 5'h0B, 2'd2, d);
			ch = k ? chanB : chanA;
			chk("coarse gain", {d[31:30], d[23:22]}, ch.coarseGain);
			chk("fine gain", d[21:16], ch.fineGain);
			chk("offset", {d[29:24], d[13:8]}, ch.offset);
			chk("chan power off", d[15], ch.powerOff);
			chk("chan sleep", d[14], ch.sleep);
			d = $random(seed);
			wr(k ? 5'h1D : 5'h1B, 2'd1, d);
			ch = k ? chanB : chanA;
			chk("aux value", {d[23:16], d[25:24]}, ch.auxValue);
			chk("aux power off", d[31], ch.auxPowerOff);
			rd(k ? 5'h1D : 5'h1B, 2'd1, {d[31:24] & 8'h83, d[23:16], 16'h0});
		end
		$display("test channels done");
		wr(5'h00, 2'd0, {8'hBF, 24'h0});
		rd(5'h00, 2'd0, {8'hAF, 24'h0});
		chk("interleaved", 1'b1, cfg.interleaved);
		chk("twos complement", 1'b1, cfg.twosComplement);
		chk("chip power down", 1'b0, coreEnable);
		chk("bandgap off", 1'b1, cfg.bandgapPowerDown);
		chk("latch falling", 1'b1, cfg.latchFalling);
		wr(5'h00, 2'd0, {8'h80, 24'h0});
		chk("dual port", 1'b0, cfg.interleaved);
		chk("offset binary", 1'b0, cfg.twosComplement);
		chk("chip running", 1'b1, coreEnable);
		chk("bandgap on", 1'b0, cfg.bandgapPowerDown);
		chk("latch rising", 1'b0, cfg.latchFalling);
		$display("test common done");
		for (int m = 0; m < 5; m++)
		begin
			wr(5'h01, 2'd0, {3'b000, 3'(m), 2'b11, 24'h0});
			chk("modulation", 5'h01 << m, cfg.modulation);
			chk("acc held", 32'h0, oscPhaseAcc);
		end
		d = $random(seed);
		wr(5'h01, 2'd0, {8'hE3, 24'h0});
		chk("rolloff", 1'b1, cfg.rolloffCompensationEnable);
		chk("interpolation", 2'h3, cfg.interpolation);
		wr(5'h08, 2'd1, d);
		chk("lp phase", {d[31:27], 11'h000}, cfg.oscillatorPhaseWord);
		wr(5'h06, 2'd0, d);
		chk("lp freq", {d[31:27], 27'h0000000}, cfg.oscillatorFreqWord);
		d = $random(seed);
		wr(5'h10, 2'd1, d);
		chk("sync div", d[31], cfg.syncDivideBy8);
		chk("sync enable", d[30], cfg.syncEnable);
		chk("gain cut", d[17], cfg.modulatorGainCut);
		chk("noise shaping", d[16], cfg.noiseShapingEnable);
		rd(5'h10, 2'd1, {d[31:24] & 8'hC0, d[23:16] & 8'h03, 16'h0});
		d = $random(seed);
		wr(5'h02, 2'd0, d);
		chk("multiplier off", d[31], cfg.multiplierPowerDown);
		chk("divider off", d[29], cfg.dividerPowerDown);
		chk("div select", d[28:27], cfg.divSelect);
		chk("clock phase", d[26:25], cfg.sampleClockPhase);
		chk("clock invert", d[24], cfg.sampleClockInvert);
		rd(5'h02, 2'd0, {d[31:24] & 8'hBF, 24'h0});
		for (int c = 0; c < 4; c++)
		begin
			if (c < 3)
			begin
				wr(5'h02, 2'd0, {3'b000, 2'(c), 3'b000, 24'h0});
				chk("divide ratio", 4'h2 << c, cfg.divideRatio);
			end
			wr(5'h02, 2'd0, {3'b100, 2'(c), 3'b000, 24'h0});
			chk("clock delay", 130 + 150 * c, cfg.clockDelayPs);
		end
		$display("test modes done");
		wr(5'h11, 2'd0, {8'h0A, 24'h0});
		wr(5'h14, 2'd1, {16'h6C6C, 16'h0});
		rd(5'h14, 2'd2, {16'h6C6C, 8'h00, 8'h0});
		wr(5'h00, 2'd0, {8'hC0, 24'h0});
		rd(5'h00, 2'd0, {8'hC0, 24'h0});
		rd(5'h06, 2'd3, 32'h2666_6666);
		chk("divide after reset", 4'h8, cfg.divideRatio);
		chk("coarse after reset", 4'hD, chanA.coarseGain);
		rd(5'h11, 2'd0, 32'h0);
		$display("test soft reset done");
		end_of_test();
	end
endmodule // interpolating_dac_control_regs_tb
